// ==== hdl/mmac_pkg.sv ====
package mmac_pkg;

  // Configuration bit positions within the memory configuration byte.
  localparam int EP_MODE_BIT   = 0;
  localparam int DRAM_SEL_BIT  = 1;
  localparam int WS_SLOW_BIT   = 4;

  // Size select codes for the symmetric two-bank layouts.
  localparam logic [2:0] SZ_2M  = 3'h2;
  localparam logic [2:0] SZ_4M  = 3'h4;
  localparam logic [2:0] SZ_16M = 3'h6;

  // Asymmetric bank select codes.
  localparam logic [1:0] AS_1M = 2'h1;
  localparam logic [1:0] AS_4M = 2'h3;

  // Bank 0 sizes in CPU address bits (byte address width).
  localparam int B0_1M_BITS   = 20;
  localparam int B0_2M_BITS   = 21;
  localparam int B0_8M_BITS   = 23;
  localparam int B0_512K_BITS = 19;

  // Reset values.
  localparam logic [11:0] MA_RST  = 12'h000;
  localparam logic [3:0]  SEL_RST = 4'hF;

  // Controller states.
  typedef enum logic [1:0] {
    MMAC_IDLE = 2'b00,
    MMAC_ROW  = 2'b01,
    MMAC_COL  = 2'b10,
    MMAC_WAIT = 2'b11
  } mmac_state_type;

endpackage

// ==== hdl/mmac_ctrl.sv ====
`timescale 1ns/1ps
module mmac_ctrl (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Configuration levels.
  input  wire logic [1:0]  enhanced_page_sel,
  input  wire logic [2:0]  mem_size_sel,
  input  wire logic        asym_cfg,
  input  wire logic [1:0]  asym_bank_sel,
  input  wire logic        sram_mode_sel,
  input  wire logic        sram_slow_ws,
  // CPU memory cycle.
  input  wire logic        cyc_req,
  input  wire logic        cyc_write,
  input  wire logic [23:1] cyc_addr,
  input  wire logic [1:0]  cyc_byte_en,
  output logic             cyc_done,
  // Memory pins.
  output logic [11:0]      dram_mux_addr,
  output logic [23:1]      sys_addr,
  output logic             row_strobe_b0_n,
  output logic             row_strobe_b1_n,
  output logic             col_strobe_b0_lo,
  output logic             col_strobe_b0_hi,
  output logic             col_strobe_b1_lo,
  output logic             col_strobe_b1_hi,
  output logic             mem_write_en
);

  mmac_pkg::mmac_state_type state_q;
  logic [11:0] row_d;
  logic [11:0] col_d;
  logic        bank1_d;
  logic        bank1_q;
  logic        write_q;
  logic [1:0]  be_q;
  logic [1:0]  ws_cnt_q;
  logic [1:0]  ws_need;
  logic        sram_on;
  logic [23:1] a;
  logic [23:0] ba;
  logic [11:0] sys_ma;
  logic [1:0]  lane_en;
  logic        bank_hi;
  logic        wr_now;

  assign a = cyc_addr;
  assign ba = {cyc_addr, 1'b0};
  // SRAM is used only when the select bit is set and DRAM select is clear.
  assign sram_on = sram_mode_sel & ~enhanced_page_sel[mmac_pkg::DRAM_SEL_BIT];

  // Address split by layout; unsupported codes take the 2M or 1M split with bank 0 only.
  always_comb begin
    row_d = mmac_pkg::MA_RST;
    col_d = mmac_pkg::MA_RST;
    bank1_d = 1'b0;
    if (asym_cfg) begin
      if (asym_bank_sel == mmac_pkg::AS_4M) begin
        row_d = {a[20], a[21], a[19:10]};
        col_d = {4'h0, a[8:1]};
        bank1_d = ba[23:mmac_pkg::B0_2M_BITS] != 3'h0;
      end else begin
        row_d = {3'h0, a[18:11], a[19]};
        col_d = {3'h0, a[9:1]};
        bank1_d = (asym_bank_sel == mmac_pkg::AS_1M) &
                  (ba[23:mmac_pkg::B0_512K_BITS] != 5'h00);
      end
    end else if (!enhanced_page_sel[mmac_pkg::EP_MODE_BIT]) begin
      row_d = {2'h0, a[19:10]};
      col_d = {3'h0, a[9:1]};
    end else begin
      unique case (mem_size_sel)
        mmac_pkg::SZ_4M: begin
          row_d = {2'h0, a[19:12], a[21], a[20]};
          col_d = {2'h0, a[10:1]};
          bank1_d = ba[23:mmac_pkg::B0_2M_BITS] != 3'h0;
        end
        mmac_pkg::SZ_16M: begin
          row_d = {1'b0, a[22], a[19:14], a[23], a[12], a[21], a[20]};
          col_d = {1'b0, a[11:1]};
          bank1_d = ba[23:mmac_pkg::B0_8M_BITS] != 1'b0;
        end
        default: begin
          row_d = {2'h0, a[19:11], a[20]};
          col_d = {3'h0, a[9:1]};
          bank1_d = (mem_size_sel == mmac_pkg::SZ_2M) &
                    (ba[23:mmac_pkg::B0_1M_BITS] != 4'h0);
        end
      endcase
    end
  end

  // Wait states for SRAM reads and writes.
  always_comb begin
    if (enhanced_page_sel == 2'b01)
      ws_need = sram_slow_ws ? 2'h2 : 2'h1;
    else
      ws_need = cyc_write ? 2'h1 : 2'h0;
  end

  // Cycle sequencing: row then column in DRAM mode; SRAM mode goes straight to its wait states.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= mmac_pkg::MMAC_IDLE;
      ws_cnt_q <= 2'h0;
      bank1_q <= 1'b0;
      write_q <= 1'b0;
      be_q <= 2'h0;
      sys_ma <= mmac_pkg::MA_RST;
    end else begin
      unique case (state_q)
        mmac_pkg::MMAC_IDLE: if (cyc_req) begin
          bank1_q <= sram_on ? ba[23] | (mem_size_sel > 3'h5) & ba[23] : bank1_d;
          write_q <= cyc_write;
          be_q <= cyc_byte_en;
          ws_cnt_q <= ws_need;
          sys_ma <= col_d;
          state_q <= sram_on ? mmac_pkg::MMAC_WAIT : mmac_pkg::MMAC_ROW;
        end
        mmac_pkg::MMAC_ROW: state_q <= mmac_pkg::MMAC_COL;
        mmac_pkg::MMAC_COL: state_q <= mmac_pkg::MMAC_IDLE;
        mmac_pkg::MMAC_WAIT: begin
          if (ws_cnt_q == 2'h0)
            state_q <= mmac_pkg::MMAC_IDLE;
          else
            ws_cnt_q <= ws_cnt_q - 2'h1;
        end
      endcase
    end
  end

  // Address pins; the column is latched so it stays stable through the strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      dram_mux_addr <= mmac_pkg::MA_RST;
      sys_addr <= 23'h000000;
    end else if (state_q == mmac_pkg::MMAC_IDLE && cyc_req) begin
      dram_mux_addr <= row_d;
      sys_addr <= sram_on ? a : {row_d[9:0], row_d[10], row_d[11], a[11:1]};
    end else if (state_q == mmac_pkg::MMAC_ROW) begin
      dram_mux_addr <= sys_ma;
      sys_addr <= {sys_ma[9:0], sys_ma[10], sys_ma[11], sys_addr[11:1]};
    end
  end

  // Lane, bank and write decode feeding the strobe process; a comb block
  // is used so that reads inside the functions are in its sensitivity.
  always_comb begin
    lane_en = be_sel(cyc_req, state_q);
    bank_hi = bank1_sel();
    wr_now  = wr_sel(cyc_req, state_q);
  end

  // Strobes and selects, active low, only for the chosen bank.
  always_ff @(posedge clk) begin
    if (rst) begin
      row_strobe_b0_n <= 1'b1;
      row_strobe_b1_n <= 1'b1;
      {col_strobe_b1_hi, col_strobe_b1_lo,
       col_strobe_b0_hi, col_strobe_b0_lo} <= mmac_pkg::SEL_RST;
      mem_write_en <= 1'b1;
      cyc_done <= 1'b0;
    end else begin
      cyc_done <= 1'b0;
      if (state_q == mmac_pkg::MMAC_IDLE && cyc_req && !sram_on) begin
        row_strobe_b0_n <= bank1_d;
        row_strobe_b1_n <= ~bank1_d;
      end else if (state_q == mmac_pkg::MMAC_ROW ||
                   (state_q == mmac_pkg::MMAC_WAIT && ws_cnt_q != 2'h0) ||
                   (state_q == mmac_pkg::MMAC_IDLE && cyc_req && sram_on)) begin
        // Byte lanes map to low and high selects of the addressed bank.
        col_strobe_b0_lo <= ~(lane_en[0] & ~bank_hi);
        col_strobe_b0_hi <= ~(lane_en[1] & ~bank_hi);
        col_strobe_b1_lo <= ~(lane_en[0] & bank_hi);
        col_strobe_b1_hi <= ~(lane_en[1] & bank_hi);
        mem_write_en <= ~wr_now;
      end else begin
        row_strobe_b0_n <= 1'b1;
        row_strobe_b1_n <= 1'b1;
        {col_strobe_b1_hi, col_strobe_b1_lo,
         col_strobe_b0_hi, col_strobe_b0_lo} <= mmac_pkg::SEL_RST;
        mem_write_en <= 1'b1;
        cyc_done <= state_q != mmac_pkg::MMAC_IDLE;
      end
    end
  end

  // Byte enables come from the port on the first cycle, then from the latch.
  function automatic logic [1:0] be_sel(input logic req,
                                        input mmac_pkg::mmac_state_type st);
    be_sel = (st == mmac_pkg::MMAC_IDLE) ? (req ? cyc_byte_en : 2'h0) : be_q;
  endfunction

  function automatic logic wr_sel(input logic req,
                                  input mmac_pkg::mmac_state_type st);
    wr_sel = (st == mmac_pkg::MMAC_IDLE) ? (req & cyc_write) : write_q;
  endfunction

  function automatic logic bank1_sel();
    bank1_sel = (state_q == mmac_pkg::MMAC_IDLE) ?
                (sram_on ? ba[23] : bank1_d) : bank1_q;
  endfunction

  // Checks on the pin behaviour.
  property p_sram_no_row;
    @(posedge clk) disable iff (rst) sram_on && state_q == mmac_pkg::MMAC_IDLE
      && cyc_req |=> row_strobe_b0_n && row_strobe_b1_n;
  endproperty
  a_sram_no_row: assert property (p_sram_no_row)
    else $error("Row strobe active in SRAM mode.");

  property p_one_bank;
    @(posedge clk) disable iff (rst) !(row_strobe_b0_n == 1'b0 &&
      row_strobe_b1_n == 1'b0);
  endproperty
  a_one_bank: assert property (p_one_bank)
    else $error("Both banks strobed.");

  property p_dram_seq;
    @(posedge clk) disable iff (rst) !sram_on && state_q ==
      mmac_pkg::MMAC_IDLE && cyc_req |=> ##2 cyc_done;
  endproperty
  a_dram_seq: assert property (p_dram_seq)
    else $error("DRAM cycle length wrong.");

  property p_reset_dram;
    @(posedge clk) rst |=> row_strobe_b0_n && row_strobe_b1_n &&
      mem_write_en;
  endproperty
  a_reset_dram: assert property (p_reset_dram)
    else $error("Outputs not idle after reset.");

  // A write in SRAM mode drives the write enable from the first cycle.
  property p_sram_we;
    @(posedge clk) disable iff (rst) sram_on && state_q ==
      mmac_pkg::MMAC_IDLE && cyc_req && cyc_write |=> !mem_write_en;
  endproperty
  a_sram_we: assert property (p_sram_we)
    else $error("Write enable idle on SRAM write.");

  // Code 00 reads take no wait state, so done follows one cycle later.
  property p_sram_ws;
    @(posedge clk) disable iff (rst) sram_on && state_q ==
      mmac_pkg::MMAC_IDLE && cyc_req && !cyc_write &&
      enhanced_page_sel == 2'b00 |=> ##1 cyc_done;
  endproperty
  a_sram_ws: assert property (p_sram_ws)
    else $error("SRAM read wait count wrong.");

  // A bank 0 access in SRAM mode leaves both bank 1 selects idle.
  property p_sram_sel_bank;
    @(posedge clk) disable iff (rst) sram_on && state_q ==
      mmac_pkg::MMAC_IDLE && cyc_req && !cyc_addr[23] |=>
      col_strobe_b1_lo && col_strobe_b1_hi;
  endproperty
  a_sram_sel_bank: assert property (p_sram_sel_bank)
    else $error("Bank 1 select active for bank 0.");

  c_sram: cover property (@(posedge clk) sram_on && cyc_req && cyc_write);
  c_dram: cover property (@(posedge clk) !sram_on && cyc_req);
  c_bank1: cover property (@(posedge clk) !row_strobe_b1_n);

endmodule

// ==== verif/mmac_mem_model.sv ====
`timescale 1ns/1ps
// Memory bank seen from its pins; it latches what each phase presents.
module mmac_mem_model (
  // Clock and capture clear.
  input wire logic        clk,
  input wire logic        clr,
  // Memory pins.
  input wire logic [11:0] ma,
  input wire logic [23:1] sa,
  input wire logic [1:0]  row_n,
  input wire logic [3:0]  sel_n,
  input wire logic        we_n
);
  logic        row_seen_q;
  logic        col_seen_q;
  logic [11:0] row_ma_q;
  logic [11:0] col_ma_q;
  logic [23:1] row_sa_q;
  logic [23:1] sa_q;
  logic [1:0]  row_n_q;
  logic [3:0]  sel_q;
  logic        we_q;
  // Only the first row strobe counts, as a bank opens its row once.
  always_ff @(posedge clk) begin
    if (clr) begin
      row_seen_q <= 1'b0;
    end else if (!row_seen_q && row_n != 2'h3) begin
      row_seen_q <= 1'b1;
      row_ma_q   <= ma;
      row_sa_q   <= sa;
      row_n_q    <= row_n;
    end
  end
  // Column strobes double as SRAM byte selects, so one latch serves both.
  always_ff @(posedge clk) begin
    if (clr) begin
      col_seen_q <= 1'b0;
    end else if (!col_seen_q && sel_n != 4'hF) begin
      col_seen_q <= 1'b1;
      col_ma_q   <= ma;
      sa_q       <= sa;
      sel_q      <= sel_n;
      we_q       <= we_n;
    end
  end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
// Runs every enhanced layout and every SRAM wait code through full cycles.
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  ep_sel = 2'h3;
  logic [2:0]  size_sel = 3'h0;
  logic        asym = 1'b0;
  logic [1:0]  asel = 2'h0;
  logic        sram = 1'b0;
  logic        slow = 1'b0;
  logic        req = 1'b0;
  logic        wr = 1'b0;
  logic [23:1] addr = 23'h0;
  logic [1:0]  be = 2'h0;
  logic        clr = 1'b0;
  logic        done;
  logic [11:0] ma;
  logic [23:1] sa;
  logic [1:0]  row_n;
  logic [3:0]  sel_n;
  logic        we_n;
  int          failures = 0;
  int          total_checks = 0;
  int          lat;
  logic [11:0] rmask [5] = '{12'h3FF, 12'h3FF, 12'h7FF, 12'h1FF, 12'hFFF};
  logic [11:0] cmask [5] = '{12'h1FF, 12'h3FF, 12'h7FF, 12'h1FF, 12'h0FF};
  logic [2:0]  sizes [3] = '{mmac_pkg::SZ_2M, mmac_pkg::SZ_4M,
                             mmac_pkg::SZ_16M};

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  mmac_ctrl u_dut (.clk(clk), .rst(rst), .enhanced_page_sel(ep_sel),
    .mem_size_sel(size_sel), .asym_cfg(asym), .asym_bank_sel(asel),
    .sram_mode_sel(sram), .sram_slow_ws(slow), .cyc_req(req),
    .cyc_write(wr), .cyc_addr(addr), .cyc_byte_en(be), .cyc_done(done),
    .dram_mux_addr(ma), .sys_addr(sa), .row_strobe_b0_n(row_n[0]),
    .row_strobe_b1_n(row_n[1]), .col_strobe_b0_lo(sel_n[0]),
    .col_strobe_b0_hi(sel_n[1]), .col_strobe_b1_lo(sel_n[2]),
    .col_strobe_b1_hi(sel_n[3]), .mem_write_en(we_n));

  mmac_mem_model u_mem (.clk(clk), .clr(clr), .ma(ma), .sa(sa),
    .row_n(row_n), .sel_n(sel_n), .we_n(we_n));

  // Compares four-state values so an unknown never passes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One CPU cycle; lat counts edges from acceptance to done.
  task automatic run(input logic w, input logic [23:0] a,
                     input logic [1:0] b);
    @(negedge clk);
    clr = 1'b1;
    req = 1'b1;
    wr = w;
    addr = a[23:1];
    be = b;
    @(negedge clk);
    clr = 1'b0;
    req = 1'b0;
    for (lat = 2; lat < 20; lat++) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    if (lat == 20) begin
      failures++;
      give_verdict();
    end
    chk({row_n, sel_n}, 6'h3F);
  endtask

  // Expected {row, column, bank} for each enhanced layout; the bank bit
  // is set once the address lies beyond the size of bank 0.
  function automatic logic [24:0] dexp(input int c, input logic [23:0] a);
    case (c)
      0: return {2'h0, a[19:11], a[20], 3'h0, a[9:1], |a[23:20]};
      1: return {2'h0, a[19:12], a[21], a[20], 2'h0, a[10:1], |a[23:21]};
      2: return {1'h0, a[22], a[19:14], a[23], a[12], a[21], a[20],
                 1'h0, a[11:1], a[23]};
      3: return {3'h0, a[18:11], a[19], 3'h0, a[9:1], |a[23:19]};
      default: return {a[20], a[21], a[19:10], 4'h0, a[8:1], |a[23:21]};
    endcase
  endfunction

  // Main sequence: reset, DRAM layouts, normal page, SRAM wait codes.
  initial begin
    logic [23:0] a;
    logic [24:0] e;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk({done, row_n, sel_n, we_n, ma}, {8'h7F, 12'h000});
    rst = 1'b0;
    // Two-bank layouts always run enhanced.
    for (int c = 0; c < 5; c++) begin
      asym = (c > 2);
      size_sel = sizes[c % 3];
      asel = (c == 3) ? mmac_pkg::AS_1M : mmac_pkg::AS_4M;
      for (int k = 0; k < 2; k++) begin
        a = k ? (~24'hA5C3E6 & 24'hFFFFFE) : 24'hA5C3E6;
        run(k[0], a, k ? 2'h2 : 2'h1);
        e = dexp(c, a);
        chk(lat, 3);
        chk(u_mem.row_ma_q & rmask[c], e[24:13] & rmask[c]);
        chk(u_mem.col_ma_q & cmask[c], e[12:1] & cmask[c]);
        chk(u_mem.row_sa_q[23:14] & rmask[c][9:0],
            e[22:13] & rmask[c][9:0]);
        chk(u_mem.row_n_q, e[0] ? 2'h1 : 2'h2);
        chk(u_mem.sel_q, {~(e[0] ? {be, 2'h0} : {2'h0, be})});
      end
      $display("DRAM layout %0d finished", c);
    end
    ep_sel = 2'h2;
    asym = 1'b0;
    a = 24'h012344;
    run(1'b0, a, 2'h3);
    chk(lat, 3);
    chk(u_mem.row_ma_q, {2'h0, a[19:10]});
    chk(u_mem.row_n_q, 2'h2);
    $display("Normal page cycle finished");
    // SRAM cycles; the bank follows address bit 23 whatever the size code.
    sram = 1'b1;
    size_sel = mmac_pkg::SZ_16M;
    for (int k = 0; k < 6; k++) begin
      ep_sel = {1'b0, k > 1};
      slow = (k > 3);
      a = (k[0] ^ k[1]) ? 24'h8ACE02 : 24'h13579A;
      run(k[0], a, k[0] ? 2'h2 : 2'h1);
      chk(lat, 2 + ((k > 1) ? 1 + (k > 3) : k[0]));
      chk(u_mem.sa_q, a[23:1]);
      chk(u_mem.sel_q, {~(a[23] ? {be, 2'h0} : {2'h0, be})});
      chk(u_mem.we_q, k[0] ? 1'b0 : 1'b1);
      chk(u_mem.row_seen_q, 1'b0);
    end
    $display("SRAM wait cases finished");
    give_verdict();
  end
endmodule
